// >>> logic/dpa_host.sv
// host controller for one port of the dual-port memory
// assumes a classic wishbone master and the memory pins wired to pin_o / pin_i
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "dpa_defines.svh"
`default_nettype none

module dpa_host (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output var  logic [31:0]          wb_dat_o,
	output var  logic                 wb_ack_o,
	// memory port pins
	output var  dpa_pkg::dpa_pin_out_type pin_o,
	input  wire dpa_pkg::dpa_pin_in_type  pin_i
);

	localparam logic [3:0] WR_CYC    = 4'(`DPA_WR_CYC - 1);
	localparam logic [3:0] RD_CYC    = 4'(`DPA_RD_CYC - 1);
	localparam logic [3:0] HOLD_CYC  = 4'(`DPA_HOLD_CYC - 1);
	localparam logic [3:0] RECOV_CYC = 4'(`DPA_RECOV_CYC - 1);

	dpa_pkg::dpa_pin_in_type  s1_q, s2_q, s3_q, filt_q;
	dpa_pkg::dpa_state_type   state_q;
	dpa_pkg::dpa_op_type      op_q;
	logic [15:0]              addr_q;
	logic [7:0]               wdata_q;
	logic [7:0]               rdata_q;
	logic [3:0]               cnt_q;
	logic                     done_q;
	logic                     coll_q;
	logic                     hit_q;
	logic                     wb_req;
	logic                     go;
	logic                     is_write;
	logic                     is_flag;

	assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign go       = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `DPA_REG_CTRL)
		&& wb_dat_i[`DPA_CTRL_GO_BIT] && (state_q == dpa_pkg::ST_IDLE);
	assign is_write = op_q[0];
	assign is_flag  = op_q[1];

	// pin synchronisers; a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		s1_q <= pin_i;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	genvar gi;
	generate
		for (gi = 0; gi < $bits(dpa_pkg::dpa_pin_in_type); gi++) begin : g_filt
			always_ff @(posedge clk) begin
				if (rst) begin
					filt_q[gi] <= 1'b1;
				end else if (s2_q[gi] == s3_q[gi]) begin
					filt_q[gi] <= s3_q[gi];
				end
			end
		end
	endgenerate

	// wishbone: answer one cycle after the request, unmapped reads zero
	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					`DPA_REG_CTRL:   wb_dat_o <= {29'h0000_0000, op_q, 1'b0};
					`DPA_REG_ADDR:   wb_dat_o <= {16'h0000, addr_q};
					`DPA_REG_WDATA:  wb_dat_o <= {24'h00_0000, wdata_q};
					`DPA_REG_STATUS: wb_dat_o <= {28'h000_0000, !filt_q.mailbox_n, coll_q,
						done_q, (state_q != dpa_pkg::ST_IDLE)};
					`DPA_REG_RDATA:  wb_dat_o <= {24'h00_0000, rdata_q};
					default:         wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// software registers; changes ignored while an access runs
	always_ff @(posedge clk) begin
		if (rst) begin
			addr_q  <= `DPA_ADDR_RST;
			wdata_q <= `DPA_WDATA_RST;
			op_q    <= dpa_pkg::OP_ARRAY_READ;
		end else if (wb_req && wb_we_i && state_q == dpa_pkg::ST_IDLE) begin
			if (wb_adr_i == `DPA_REG_ADDR && wb_sel_i[0]) begin
				addr_q[7:0] <= wb_dat_i[7:0];
			end
			if (wb_adr_i == `DPA_REG_ADDR && wb_sel_i[1]) begin
				addr_q[15:8] <= wb_dat_i[15:8];
			end
			if (wb_adr_i == `DPA_REG_WDATA && wb_sel_i[0]) begin
				wdata_q <= wb_dat_i[7:0];
			end
			if (wb_adr_i == `DPA_REG_CTRL && wb_sel_i[0]) begin
				op_q <= dpa_pkg::dpa_op_type'(wb_dat_i[`DPA_CTRL_OP_MSB:`DPA_CTRL_OP_LSB]);
			end
		end
	end

	// sticky status; a new go clears, completion can never coincide with go
	always_ff @(posedge clk) begin
		if (rst) begin
			done_q <= 1'b0;
			coll_q <= 1'b0;
		end else if (go) begin
			done_q <= 1'b0;
			coll_q <= 1'b0;
		end else begin
			if (state_q == dpa_pkg::ST_RECOV && cnt_q == 4'h0) begin
				done_q <= 1'b1;
			end
			if (state_q == dpa_pkg::ST_ACT && !filt_q.collision_n) begin
				coll_q <= 1'b1;
			end
		end
	end

	// access sequencer driving the memory pins
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= dpa_pkg::ST_IDLE;
			cnt_q   <= 4'h0;
			hit_q   <= 1'b0;
			rdata_q <= 8'h00;
			pin_o   <= '{addr: 16'h0000, port_sel_n: 1'b1, flag_select_n: 1'b1, wr_n: 1'b1,
				out_drv_n: 1'b1, data: 8'h00, data_oe: 1'b0};
		end else begin
			unique case (state_q)
				dpa_pkg::ST_IDLE: begin
					if (go) begin
						state_q <= dpa_pkg::ST_SETUP;
					end
				end
				dpa_pkg::ST_SETUP: begin
					// address moves only with every select high
					pin_o.addr    <= addr_q;
					pin_o.data    <= wdata_q;
					pin_o.data_oe <= is_write;
					hit_q         <= 1'b0;
					cnt_q         <= is_write ? WR_CYC : RD_CYC;
					state_q       <= dpa_pkg::ST_ACT;
				end
				dpa_pkg::ST_ACT: begin
					// select and strobe fall together so outputs stay off
					pin_o.port_sel_n    <= is_flag;
					pin_o.flag_select_n <= !is_flag;
					pin_o.wr_n          <= !is_write;
					// output drive kept high on writes; minimum pulse then suffices
					pin_o.out_drv_n     <= is_write;
					if (!filt_q.collision_n) begin
						// strobe held while the port is blocked
						hit_q <= 1'b1;
						if (!is_write) begin
							cnt_q <= RD_CYC;
						end
					end else if (cnt_q != 4'h0) begin
						cnt_q <= cnt_q - 4'h1;
					end else if (is_write && hit_q) begin
						cnt_q   <= HOLD_CYC;
						state_q <= dpa_pkg::ST_HOLD;
					end else begin
						// flag read shows the flag on every pin
						if (!is_write) begin
							rdata_q <= filt_q.data;
						end
						cnt_q   <= RECOV_CYC;
						state_q <= dpa_pkg::ST_RECOV;
						pin_o.wr_n          <= 1'b1;
						pin_o.out_drv_n     <= 1'b1;
						pin_o.port_sel_n    <= 1'b1;
						pin_o.flag_select_n <= 1'b1;
					end
				end
				dpa_pkg::ST_HOLD: begin
					// deferred write completes after collision release
					if (cnt_q != 4'h0) begin
						cnt_q <= cnt_q - 4'h1;
					end else begin
						cnt_q               <= RECOV_CYC;
						state_q             <= dpa_pkg::ST_RECOV;
						pin_o.wr_n          <= 1'b1;
						pin_o.port_sel_n    <= 1'b1;
						pin_o.flag_select_n <= 1'b1;
					end
				end
				dpa_pkg::ST_RECOV: begin
					// gap also covers flag write-to-read spacing
					pin_o.data_oe <= 1'b0;
					if (cnt_q != 4'h0) begin
						cnt_q <= cnt_q - 4'h1;
					end else begin
						state_q <= dpa_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= dpa_pkg::ST_IDLE;
				end
			endcase
		end
	end

endmodule : dpa_host

`default_nettype wire

// >>> inc/dpa_defines.svh
// constants for the dual-port arbitration host controller
// assumes a 250 MHz clock; every count is derived from its time in ns, the access counts plus the sync stages
`ifndef DPA_DEFINES_SVH
`define DPA_DEFINES_SVH

`define DPA_CLK_PERIOD_PS      32'd4000
`define DPA_CYC_UP(ns)         (((ns) * 32'd1000 + `DPA_CLK_PERIOD_PS - 32'd1) / `DPA_CLK_PERIOD_PS)

// register byte offsets
`define DPA_REG_CTRL           8'h00
`define DPA_REG_ADDR           8'h04
`define DPA_REG_WDATA          8'h08
`define DPA_REG_STATUS         8'h0C
`define DPA_REG_RDATA          8'h10

// ctrl fields
`define DPA_CTRL_GO_BIT        0
`define DPA_CTRL_OP_LSB        1
`define DPA_CTRL_OP_MSB        2

// status fields
`define DPA_STAT_BUSY_BIT      0
`define DPA_STAT_DONE_BIT      1
`define DPA_STAT_COLL_BIT      2
`define DPA_STAT_MBOX_BIT      3

// reset values
`define DPA_ADDR_RST           16'h0000
`define DPA_WDATA_RST          8'h00

// mailbox locations
`define DPA_MBOX_LEFT_ADDR     16'hFFFE
`define DPA_MBOX_RIGHT_ADDR    16'hFFFF

// times in ns and the synchroniser stage count
`define DPA_WR_PULSE_NS        32'd12
`define DPA_BUSY_ACCESS_NS     32'd15
`define DPA_READ_ACCESS_NS     32'd15
`define DPA_WR_HOLD_NS         32'd12
`define DPA_SEM_WR2RD_NS       32'd5
`define DPA_SYNC_STAGES        32'd3

// cycle counts
`define DPA_WR_CYC    ((`DPA_CYC_UP(`DPA_WR_PULSE_NS) > `DPA_CYC_UP(`DPA_BUSY_ACCESS_NS) ? \
	`DPA_CYC_UP(`DPA_WR_PULSE_NS) : `DPA_CYC_UP(`DPA_BUSY_ACCESS_NS)) + `DPA_SYNC_STAGES)
`define DPA_RD_CYC             (`DPA_CYC_UP(`DPA_READ_ACCESS_NS) + `DPA_SYNC_STAGES)
`define DPA_HOLD_CYC           `DPA_CYC_UP(`DPA_WR_HOLD_NS)
`define DPA_RECOV_CYC          `DPA_CYC_UP(`DPA_SEM_WR2RD_NS)

`endif

// >>> inc/dpa_pkg.sv
// types for the dual-port arbitration host controller
// assumes nothing beyond the defines header
package dpa_pkg;

	typedef enum logic [1:0] {
		OP_ARRAY_READ  = 2'b00,
		OP_ARRAY_WRITE = 2'b01,
		OP_FLAG_READ   = 2'b10,
		OP_FLAG_WRITE  = 2'b11
	} dpa_op_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_ACT   = 3'b010,
		ST_HOLD  = 3'b011,
		ST_RECOV = 3'b100
	} dpa_state_type;

	// pins driven toward the memory port
	typedef struct packed {
		logic [15:0] addr;
		logic        port_sel_n;
		logic        flag_select_n;
		logic        wr_n;
		logic        out_drv_n;
		logic [7:0]  data;
		logic        data_oe;
	} dpa_pin_out_type;

	// pins sampled from the memory port
	typedef struct packed {
		logic        collision_n;
		logic        mailbox_n;
		logic [7:0]  data;
	} dpa_pin_in_type;

endpackage : dpa_pkg

// >>> sim/dpa_host_properties.sv
// checker for the host controller pins and its bus
// assumes binding into dpa_host; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module dpa_host_properties (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     rst,
	// bus
	input wire logic                     wb_cyc_i,
	input wire logic                     wb_stb_i,
	input wire logic                     wb_ack_o,
	// memory pins
	input wire dpa_pkg::dpa_pin_out_type pin_o,
	input wire dpa_pkg::dpa_pin_in_type  pin_i
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_addr; (!pin_o.wr_n && !pin_o.port_sel_n) ##1 (!pin_o.wr_n && !pin_o.port_sel_n)
		|-> $stable(pin_o.addr); endproperty
	a_addr: assert property (p_addr) else $error("address moved inside a write");
	property p_oe; pin_o.data_oe |-> pin_o.out_drv_n; endproperty
	a_oe: assert property (p_oe) else $error("data driven against output");
	// sequencer keeps the strobe low for six samples: count 6..0, last step raises it
	property p_pulse; $fell(pin_o.wr_n) |-> !pin_o.wr_n [*6]; endproperty
	a_pulse: assert property (p_pulse) else $error("write strobe too short");
	property p_rdwr; !pin_o.out_drv_n |-> pin_o.wr_n; endproperty
	a_rdwr: assert property (p_rdwr) else $error("output drive low in a write");
	property p_sel; !(!pin_o.port_sel_n && !pin_o.flag_select_n); endproperty
	a_sel: assert property (p_sel) else $error("both selects low");
	property p_strobe; $fell(pin_o.wr_n) |-> !pin_o.port_sel_n || !pin_o.flag_select_n;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe without select");
	property p_data; !pin_o.wr_n |-> pin_o.data_oe && $stable(pin_o.data); endproperty
	a_data: assert property (p_data) else $error("write data not held");
	property p_hold; $rose(pin_i.collision_n) && !pin_o.wr_n |=> !pin_o.wr_n [*5]; endproperty
	a_hold: assert property (p_hold) else $error("strobe released after collision");
	property p_ack; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i) ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bad acknowledge");
endmodule : dpa_host_properties
bind dpa_host dpa_host_properties dpa_host_properties_i (.clk(clk), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pin_o(pin_o), .pin_i(pin_i));
`default_nettype wire

// >>> sim/dpa_mem_model.sv
// one port of the dual-port memory, seen from the host
// assumes the peer port is stood in for by bench inputs
`timescale 1ns/1ps
`default_nettype none
module dpa_mem_model (
	// host side
	input  wire logic                     clk,
	input  wire dpa_pkg::dpa_pin_out_type pin_o,
	output var  dpa_pkg::dpa_pin_in_type  pin_i,
	// peer stand-in
	input  wire logic                     coll_n,
	input  wire logic                     mail_set,
	output var  logic                     peer_mail_n
);
	logic [7:0]               mem [0:65535];
	logic [7:0]               sem_q = 8'hFF;
	logic [7:0]               last_q = 8'h00;
	logic [7:0]               rd;
	logic                     mail_n = 1'b1;
	dpa_pkg::dpa_pin_out_type p = '1;
	initial peer_mail_n = 1'b1;
	// strobe edge judged on last sample so selects rising with it still count
	always @(posedge clk) begin
		p <= pin_o;
		if (!p.wr_n && pin_o.wr_n && coll_n) begin
			if (!p.port_sel_n) mem[p.addr] <= p.data;
			if (!p.flag_select_n) sem_q[p.addr[2:0]] <= p.data[0];
			if (!p.port_sel_n && p.addr == 16'hFFFF) peer_mail_n <= 1'b0;
		end
		if (mail_set) mail_n <= 1'b0;
		if (!pin_o.port_sel_n && !pin_o.out_drv_n && pin_o.addr == 16'hFFFE) mail_n <= 1'b1;
		last_q <= pin_i.data;
	end
	// released bus toggles so a stale value never reads as good
	always @* begin
		if (!pin_o.out_drv_n && pin_o.wr_n && !pin_o.data_oe && !pin_o.port_sel_n)
			rd = mem[pin_o.addr];
		else if (!pin_o.out_drv_n && pin_o.wr_n && !pin_o.data_oe && !pin_o.flag_select_n)
			rd = {8{sem_q[pin_o.addr[2:0]]}};
		else
			rd = ~last_q;
	end
	// peer arbitration result stood in by the bench's collision level
	assign pin_i = {coll_n, mail_n, rd};
endmodule : dpa_mem_model
`default_nettype wire

// >>> sim/dpa_host_test.sv
// bench for the host controller over its bus
// assumes the memory model on the pins, peer side driven here
`timescale 1ns/1ps
`include "dpa_defines.svh"
`default_nettype none
module dpa_host_test;
	logic                     clk, rst, cyc, stb, we, coll_n, mail_set, ack, peer_n;
	logic [7:0]               adr;
	logic [31:0]              dw, dr, rv;
	int                       err_total, cmp_count, cyc_n;
	dpa_pkg::dpa_pin_out_type po;
	dpa_pkg::dpa_pin_in_type  pi;
	dpa_host dpa_host_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.pin_o(po), .pin_i(pi));
	dpa_mem_model dpa_mem_model_i (.clk(clk), .pin_o(po), .pin_i(pi), .coll_n(coll_n),
		.mail_set(mail_set), .peer_mail_n(peer_n));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rv = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic op(input logic [1:0] o, input logic [15:0] a, input logic [7:0] d);
		wb(1'b1, `DPA_REG_ADDR, 32'(a));
		wb(1'b1, `DPA_REG_WDATA, 32'(d));
		wb(1'b1, `DPA_REG_CTRL, 32'({o, 1'b1}));
	endtask : op
	task automatic fin;
		do wb(1'b0, `DPA_REG_STATUS, 32'h0000_0000); while (rv[`DPA_STAT_DONE_BIT] !== 1'b1);
	endtask : fin
	task automatic results;
		$display("compares=%0d errors=%0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			err_total++;
			results;
		end
	end
	initial begin
		{rst, cyc, stb, we, mail_set, coll_n, adr, dw} = {6'h21, 8'h00, 32'h0000_0000};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, `DPA_REG_ADDR, 32'h0000_0000);
		chk(rv, 32'h0000_0000);
		wb(1'b0, 8'h14, 32'h0000_0000);
		chk(rv, 32'h0000_0000);
		op(2'd1, 16'h1234, 8'hA5);
		fin;
		op(2'd0, 16'h1234, 8'h00);
		fin;
		wb(1'b0, `DPA_REG_RDATA, 32'h0000_0000);
		chk(rv, 32'h0000_00A5);
		// only data bit zero may reach the flag; alias through address bit 3
		for (int v = 0; v < 2; v++) begin
			op(2'd3, 16'h0005, v ? 8'h01 : 8'hFE);
			fin;
			op(2'd2, 16'h000D, 8'h00);
			fin;
			wb(1'b0, `DPA_REG_RDATA, 32'h0000_0000);
			chk(rv, v ? 32'h0000_00FF : 32'h0000_0000);
		end
		coll_n <= 1'b0;
		op(2'd1, 16'h0042, 8'h3C);
		repeat (30) @(posedge clk);
		wb(1'b0, `DPA_REG_STATUS, 32'h0000_0000);
		chk(rv[`DPA_STAT_BUSY_BIT], 1'b1);
		coll_n <= 1'b1;
		fin;
		chk(rv[`DPA_STAT_COLL_BIT], 1'b1);
		op(2'd0, 16'h0042, 8'h00);
		fin;
		wb(1'b0, `DPA_REG_RDATA, 32'h0000_0000);
		chk(rv, 32'h0000_003C);
		mail_set <= 1'b1;
		@(posedge clk);
		mail_set <= 1'b0;
		repeat (10) @(posedge clk);
		wb(1'b0, `DPA_REG_STATUS, 32'h0000_0000);
		chk(rv[`DPA_STAT_MBOX_BIT], 1'b1);
		op(2'd0, 16'hFFFE, 8'h00);
		fin;
		wb(1'b0, `DPA_REG_STATUS, 32'h0000_0000);
		chk(rv[`DPA_STAT_MBOX_BIT], 1'b0);
		op(2'd1, 16'hFFFF, 8'h5A);
		fin;
		chk(peer_n, 1'b0);
		results;
	end
endmodule : dpa_host_test
`default_nettype wire
